/* File: src/usf_status.sv */
// uart status flag logic with avalon-mm register slave and interrupt
`timescale 1ns/100ps
// How it works
// - rx_dma_done_flag reads 1 while the receive dma end signal is high.
// - tx_dma_done_flag reads 1 while the transmit dma end signal is high.
// - overrun_flag sets on any overrun and holds until clear_status_command.
// - the framing flag sets on any framing error and holds until the clear.
// - parity_error_flag sets on any parity error and holds until the clear.
// - tx_idle_flag reads 0 if holding full, shifter busy or tx disabled.
// - tx_idle_flag reads 1 only when holding and shifter are both empty.
// - tx_holding_free_flag reads 1 when holding is empty and tx enabled.
module usf_status (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [usf_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic rx_dma_end,
    input wire logic tx_dma_end,
    input wire logic rx_overrun,
    input wire logic rx_frame_err,
    input wire logic rx_parity_err,
    input wire logic tx_holding_full,
    input wire logic tx_shifter_busy,
    output logic tx_enable,
    output logic irq
);
    typedef struct packed {
        logic [31:0] rdata;
        logic ack;
        logic overrun;
        logic frame;
        logic parity;
        logic tx_en;
        logic [usf_pkg::IRQ_W-1:0] ev;
        logic [usf_pkg::IRQ_W-1:0] ev_en;
        logic rx_dma_prev;
        logic tx_dma_prev;
    } usf_state_t;

    usf_state_t st_q;
    usf_state_t st_d;
    logic rx_dma_done_flag;
    logic tx_dma_done_flag;
    logic tx_idle_flag;
    logic tx_holding_free_flag;
    logic clear_status_command;
    logic wr_take;
    logic rd_take;
    logic [usf_pkg::IRQ_W-1:0] ev_set;
    logic [31:0] status_word;

    function automatic logic hit(input logic [usf_pkg::ADDR_W-1:0] a,
                                 input logic [usf_pkg::ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    assign rx_dma_done_flag = rx_dma_end;
    assign tx_dma_done_flag = tx_dma_end;
    // idle needs both stages empty and the transmitter running
    assign tx_idle_flag = st_q.tx_en && !tx_holding_full
                          && !tx_shifter_busy;
    assign tx_holding_free_flag = st_q.tx_en && !tx_holding_full;

    // one wait cycle per access so read data comes from a flip-flop
    assign waitrequest = (read || write) && !st_q.ack;
    assign wr_take = write && st_q.ack;
    assign rd_take = read && !st_q.ack;
    assign clear_status_command = write && !st_q.ack
        && hit(address, usf_pkg::OFF_CONTROL)
        && writedata[usf_pkg::BIT_CLR_STATUS];
    assign readdata = st_q.rdata;
    assign tx_enable = st_q.tx_en;
    assign irq = |(st_q.ev & st_q.ev_en);

    always_comb
    begin
        status_word = usf_pkg::READ_UNMAPPED;
        status_word[usf_pkg::BIT_TX_FREE] = tx_holding_free_flag;
        status_word[usf_pkg::BIT_RX_DMA] = rx_dma_done_flag;
        status_word[usf_pkg::BIT_TX_DMA] = tx_dma_done_flag;
        status_word[usf_pkg::BIT_OVERRUN] = st_q.overrun;
        status_word[usf_pkg::BIT_FRAME] = st_q.frame;
        status_word[usf_pkg::BIT_PARITY] = st_q.parity;
        status_word[usf_pkg::BIT_TX_IDLE] = tx_idle_flag;
        ev_set = '0;
        ev_set[usf_pkg::EV_OVERRUN] = rx_overrun;
        ev_set[usf_pkg::EV_FRAME] = rx_frame_err;
        ev_set[usf_pkg::EV_PARITY] = rx_parity_err;
        ev_set[usf_pkg::EV_RX_DMA] = rx_dma_end && !st_q.rx_dma_prev;
        ev_set[usf_pkg::EV_TX_DMA] = tx_dma_end && !st_q.tx_dma_prev;
    end

    always_comb
    begin
        st_d = st_q;
        st_d.ack = (read || write) && !st_q.ack;
        st_d.rx_dma_prev = rx_dma_end;
        st_d.tx_dma_prev = tx_dma_end;
        if (rd_take)
        begin
            if (hit(address, usf_pkg::OFF_STATUS))
                st_d.rdata = status_word;
            else if (hit(address, usf_pkg::OFF_CONTROL))
                st_d.rdata = {31'h0000_0000, st_q.tx_en};
            else if (hit(address, usf_pkg::OFF_IRQ_EN))
                st_d.rdata = {27'h000_0000, st_q.ev_en};
            else if (hit(address, usf_pkg::OFF_IRQ_CLR))
                st_d.rdata = {27'h000_0000, st_q.ev};
            else
                st_d.rdata = usf_pkg::READ_UNMAPPED;
        end
        if (wr_take && hit(address, usf_pkg::OFF_CONTROL))
            st_d.tx_en = writedata[usf_pkg::BIT_TX_ENABLE];
        if (wr_take && hit(address, usf_pkg::OFF_IRQ_EN))
            st_d.ev_en = writedata[usf_pkg::IRQ_W-1:0];
        if (wr_take && hit(address, usf_pkg::OFF_IRQ_CLR))
            st_d.ev = st_q.ev & ~writedata[usf_pkg::IRQ_W-1:0];
        st_d.ev = st_d.ev | ev_set;
        // a new error in the clearing cycle survives the clear
        if (clear_status_command)
        begin
            st_d.overrun = 1'b0;
            st_d.frame = 1'b0;
            st_d.parity = 1'b0;
        end
        if (rx_overrun)
            st_d.overrun = 1'b1;
        if (rx_frame_err)
            st_d.frame = 1'b1;
        if (rx_parity_err)
            st_d.parity = 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            st_q <= '0;
            st_q.ev <= usf_pkg::IRQ_RESET;
        end
        else
            st_q <= st_d;
    end

    // bits of the status word that carry a flag; all others read zero
    localparam logic [31:0] STATUS_USED =
        (32'h0000_0001 << usf_pkg::BIT_TX_FREE)
        | (32'h0000_0001 << usf_pkg::BIT_RX_DMA)
        | (32'h0000_0001 << usf_pkg::BIT_TX_DMA)
        | (32'h0000_0001 << usf_pkg::BIT_OVERRUN)
        | (32'h0000_0001 << usf_pkg::BIT_FRAME)
        | (32'h0000_0001 << usf_pkg::BIT_PARITY)
        | (32'h0000_0001 << usf_pkg::BIT_TX_IDLE);

    // sticky receive errors: a new error beats the clear
    chk_overrun_sets: assert property (
        @(posedge mclk) disable iff (reset)
        rx_overrun |=> st_q.overrun)
        else $error("overrun flag did not set");
    chk_overrun_holds: assert property (
        @(posedge mclk) disable iff (reset)
        st_q.overrun && !clear_status_command |=> st_q.overrun)
        else $error("overrun flag dropped without clear");
    chk_overrun_clear: assert property (
        @(posedge mclk) disable iff (reset)
        clear_status_command && !rx_overrun |=> !st_q.overrun)
        else $error("overrun flag not cleared");
    chk_overrun_rises: assert property (
        @(posedge mclk) disable iff (reset)
        $rose(st_q.overrun) |-> $past(rx_overrun))
        else $error("overrun flag rose without error");
    chk_frame_sets: assert property (
        @(posedge mclk) disable iff (reset)
        rx_frame_err |=> st_q.frame)
        else $error("framing flag did not set");
    chk_frame_holds: assert property (
        @(posedge mclk) disable iff (reset)
        st_q.frame && !clear_status_command |=> st_q.frame)
        else $error("framing flag dropped without clear");
    chk_frame_clear: assert property (
        @(posedge mclk) disable iff (reset)
        clear_status_command && !rx_frame_err |=> !st_q.frame)
        else $error("framing flag not cleared");
    chk_frame_rises: assert property (
        @(posedge mclk) disable iff (reset)
        $rose(st_q.frame) |-> $past(rx_frame_err))
        else $error("framing flag rose without error");
    chk_parity_sets: assert property (
        @(posedge mclk) disable iff (reset)
        rx_parity_err |=> st_q.parity)
        else $error("parity flag did not set");
    chk_parity_holds: assert property (
        @(posedge mclk) disable iff (reset)
        st_q.parity && !clear_status_command |=> st_q.parity)
        else $error("parity flag dropped without clear");
    chk_parity_clear: assert property (
        @(posedge mclk) disable iff (reset)
        clear_status_command && !rx_parity_err |=> !st_q.parity)
        else $error("parity flag not cleared");
    chk_parity_rises: assert property (
        @(posedge mclk) disable iff (reset)
        $rose(st_q.parity) |-> $past(rx_parity_err))
        else $error("parity flag rose without error");
    chk_read_keeps: assert property (
        @(posedge mclk) disable iff (reset)
        st_q.parity && rd_take && !clear_status_command |=> st_q.parity)
        else $error("read cleared a sticky flag");
    chk_read_keeps_frame: assert property (
        @(posedge mclk) disable iff (reset)
        st_q.frame && rd_take && !clear_status_command |=> st_q.frame)
        else $error("read cleared the framing flag");
    chk_clear_once: assert property (
        @(posedge mclk) disable iff (reset)
        clear_status_command |-> write && waitrequest)
        else $error("status clear outside first write cycle");

    // status word as software reads it, one cycle after the request
    chk_rx_dma_flag: assert property (
        @(posedge mclk) disable iff (reset)
        rd_take && hit(address, usf_pkg::OFF_STATUS) |=>
        readdata[usf_pkg::BIT_RX_DMA] == $past(rx_dma_end))
        else $error("rx dma flag mismatch");
    chk_tx_dma_flag: assert property (
        @(posedge mclk) disable iff (reset)
        rd_take && hit(address, usf_pkg::OFF_STATUS) |=>
        readdata[usf_pkg::BIT_TX_DMA] == $past(tx_dma_end))
        else $error("tx dma flag mismatch");
    chk_read_overrun: assert property (
        @(posedge mclk) disable iff (reset)
        rd_take && hit(address, usf_pkg::OFF_STATUS) |=>
        readdata[usf_pkg::BIT_OVERRUN] == $past(st_q.overrun))
        else $error("overrun flag read wrong");
    chk_read_frame: assert property (
        @(posedge mclk) disable iff (reset)
        rd_take && hit(address, usf_pkg::OFF_STATUS) |=>
        readdata[usf_pkg::BIT_FRAME] == $past(st_q.frame))
        else $error("framing flag read wrong");
    chk_read_parity: assert property (
        @(posedge mclk) disable iff (reset)
        rd_take && hit(address, usf_pkg::OFF_STATUS) |=>
        readdata[usf_pkg::BIT_PARITY] == $past(st_q.parity))
        else $error("parity flag read wrong");
    chk_idle_zero: assert property (
        @(posedge mclk) disable iff (reset)
        tx_holding_full || tx_shifter_busy || !st_q.tx_en |-> !tx_idle_flag)
        else $error("idle flag high while busy");
    chk_idle_one: assert property (
        @(posedge mclk) disable iff (reset)
        tx_idle_flag |-> !tx_holding_full && !tx_shifter_busy)
        else $error("idle flag high with character");
    chk_read_idle: assert property (
        @(posedge mclk) disable iff (reset)
        rd_take && hit(address, usf_pkg::OFF_STATUS) |=>
        readdata[usf_pkg::BIT_TX_IDLE] == ($past(tx_enable)
        && !$past(tx_holding_full) && !$past(tx_shifter_busy)))
        else $error("idle flag read wrong");
    chk_holding_free: assert property (
        @(posedge mclk) disable iff (reset)
        rd_take && hit(address, usf_pkg::OFF_STATUS) |=>
        readdata[usf_pkg::BIT_TX_FREE] ==
        ($past(tx_enable) && !$past(tx_holding_full)))
        else $error("holding free flag wrong");
    chk_free_disabled: assert property (
        @(posedge mclk) disable iff (reset)
        !tx_enable |-> !tx_holding_free_flag && !tx_idle_flag)
        else $error("transmit flags high while disabled");
    chk_free_full: assert property (
        @(posedge mclk) disable iff (reset)
        tx_holding_full |-> !tx_holding_free_flag)
        else $error("holding free flag high with character");
    chk_status_spare: assert property (
        @(posedge mclk) disable iff (reset)
        rd_take && hit(address, usf_pkg::OFF_STATUS) |=>
        (readdata & ~STATUS_USED) == '0)
        else $error("unused status bit read as one");

    // register bus: exactly one wait cycle, data held between reads
    chk_wait_first: assert property (
        @(posedge mclk) disable iff (reset)
        $rose(read || write) |-> waitrequest)
        else $error("no wait cycle at start of access");
    chk_wait_one: assert property (
        @(posedge mclk) disable iff (reset)
        (read || write) && waitrequest ##1 (read || write)
        |-> !waitrequest)
        else $error("more than one wait cycle");
    chk_wait_idle: assert property (
        @(posedge mclk) disable iff (reset)
        !read && !write |-> !waitrequest)
        else $error("wait request without access");
    chk_rdata_holds: assert property (
        @(posedge mclk) disable iff (reset)
        !rd_take |=> $stable(readdata))
        else $error("read data changed without a read");
    chk_read_control: assert property (
        @(posedge mclk) disable iff (reset)
        rd_take && hit(address, usf_pkg::OFF_CONTROL) |=>
        readdata[usf_pkg::BIT_TX_ENABLE] == $past(tx_enable)
        && !readdata[usf_pkg::BIT_CLR_STATUS])
        else $error("control register read wrong");
    chk_read_unmapped: assert property (
        @(posedge mclk) disable iff (reset)
        rd_take && !hit(address, usf_pkg::OFF_STATUS)
        && !hit(address, usf_pkg::OFF_CONTROL)
        && !hit(address, usf_pkg::OFF_IRQ_EN)
        && !hit(address, usf_pkg::OFF_IRQ_CLR)
        |=> readdata == usf_pkg::READ_UNMAPPED)
        else $error("unmapped read not zero");
    chk_write_tx_en: assert property (
        @(posedge mclk) disable iff (reset)
        wr_take && hit(address, usf_pkg::OFF_CONTROL) |=>
        tx_enable == $past(writedata[usf_pkg::BIT_TX_ENABLE]))
        else $error("transmit enable not written");
    chk_tx_en_holds: assert property (
        @(posedge mclk) disable iff (reset)
        !(wr_take && hit(address, usf_pkg::OFF_CONTROL))
        |=> $stable(tx_enable))
        else $error("transmit enable changed without write");

    // interrupt events: sticky until written one, level output
    chk_overrun_event: assert property (
        @(posedge mclk) disable iff (reset)
        rx_overrun |=> st_q.ev[usf_pkg::EV_OVERRUN])
        else $error("overrun event not latched");
    chk_rx_dma_event: assert property (
        @(posedge mclk) disable iff (reset)
        $rose(rx_dma_end) |=> st_q.ev[usf_pkg::EV_RX_DMA])
        else $error("rx dma event not latched");
    chk_tx_dma_event: assert property (
        @(posedge mclk) disable iff (reset)
        $rose(tx_dma_end) |=> st_q.ev[usf_pkg::EV_TX_DMA])
        else $error("tx dma event not latched");
    chk_event_sticky: assert property (
        @(posedge mclk) disable iff (reset)
        !(wr_take && hit(address, usf_pkg::OFF_IRQ_CLR))
        |=> (st_q.ev & $past(st_q.ev)) == $past(st_q.ev))
        else $error("event dropped without clear");
    chk_event_clear: assert property (
        @(posedge mclk) disable iff (reset)
        wr_take && hit(address, usf_pkg::OFF_IRQ_CLR) && ev_set == '0
        |=> (st_q.ev & $past(writedata[usf_pkg::IRQ_W-1:0])) == '0)
        else $error("event not cleared by write");
    chk_irq_en_write: assert property (
        @(posedge mclk) disable iff (reset)
        wr_take && hit(address, usf_pkg::OFF_IRQ_EN) |=>
        st_q.ev_en == $past(writedata[usf_pkg::IRQ_W-1:0]))
        else $error("interrupt enable not written");
    chk_irq_quiet: assert property (
        @(posedge mclk) disable iff (reset)
        st_q.ev_en == '0 |-> !irq)
        else $error("interrupt high with all enables off");
    chk_irq_raised: assert property (
        @(posedge mclk) disable iff (reset)
        (st_q.ev & st_q.ev_en) != '0 |-> irq)
        else $error("interrupt low with enabled event");
endmodule : usf_status

/* File: src/usf_pkg.sv */
// package: register map and field positions of the uart status flag block
package usf_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_STATUS = 4'h0;
    localparam logic [3:0] OFF_CONTROL = 4'h4;
    localparam logic [3:0] OFF_IRQ_EN = 4'h8;
    localparam logic [3:0] OFF_IRQ_CLR = 4'hC;
    // status register bit positions
    localparam int BIT_TX_FREE = 1;
    localparam int BIT_RX_DMA = 3;
    localparam int BIT_TX_DMA = 4;
    localparam int BIT_OVERRUN = 5;
    localparam int BIT_FRAME = 6;
    localparam int BIT_PARITY = 7;
    localparam int BIT_TX_IDLE = 9;
    // control register bit positions
    localparam int BIT_CLR_STATUS = 8;
    localparam int BIT_TX_ENABLE = 0;
    // sticky interrupt event bits
    localparam int IRQ_W = 5;
    localparam int EV_OVERRUN = 0;
    localparam int EV_FRAME = 1;
    localparam int EV_PARITY = 2;
    localparam int EV_RX_DMA = 3;
    localparam int EV_TX_DMA = 4;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h0;
endpackage : usf_pkg

/* File: tb/usf_line_model.sv */
// far-side model: drives the receive, dma and transmit status levels
`timescale 1ns/100ps
module usf_line_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [6:0] req,
    output logic [6:0] lvl
);
    // registered so every level changes just after an edge, like real logic
    always_ff @(posedge mclk)
    begin
        lvl <= reset ? 7'h00 : req;
    end
endmodule : usf_line_model

/* File: tb/usf_status_tb.sv */
// testbench: uart status flags against a behavioural model
`timescale 1ns/100ps
module usf_status_tb;
    logic mclk = 0, reset = 1, read = 0, write = 0, waitrequest, tx_enable, irq;
    logic [3:0] address = 4'h0;
    logic [31:0] writedata = 32'h0000_0000, readdata, q, r;
    logic [6:0] ev = 7'h00, lvl;
    logic [2:0] sticky = 3'h0, seen = 3'h0;
    logic en = 0;
    int failures = 0, checked = 0;
    always #2 mclk = ~mclk;
    usf_line_model line (.mclk(mclk), .reset(reset), .req(ev), .lvl(lvl));
    usf_status uut (.mclk(mclk), .reset(reset), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .rx_dma_end(lvl[0]), .tx_dma_end(lvl[1]), .rx_overrun(lvl[2]),
        .rx_frame_err(lvl[3]), .rx_parity_err(lvl[4]),
        .tx_holding_full(lvl[5]), .tx_shifter_busy(lvl[6]),
        .tx_enable(tx_enable), .irq(irq));
    task automatic results;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_pin(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %0t pin got %b exp %b", $time, got, exp);
        end
    endtask : chk_pin
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        address <= a;
        writedata <= d;
        read <= ~wr;
        write <= wr;
        // no cycle count assumed: only the watchdog ends a stuck wait
        do
        begin
            @(posedge mclk);
        end
        while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
    endtask : bus
    function automatic logic [31:0] st();
        logic [31:0] s;
        s = 32'h0000_0000;
        s[usf_pkg::BIT_TX_FREE] = en & ~ev[5];
        s[usf_pkg::BIT_RX_DMA] = ev[0];
        s[usf_pkg::BIT_TX_DMA] = ev[1];
        s[usf_pkg::BIT_PARITY:usf_pkg::BIT_OVERRUN] = sticky;
        s[usf_pkg::BIT_TX_IDLE] = en & ~ev[5] & ~ev[6];
        return s;
    endfunction : st
    // cut a hang short well beyond the expected few hundred cycles
    initial
    begin
        #100000;
        failures++;
        results();
    end
    initial
    begin
        void'($urandom(14333));
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        bus(0, usf_pkg::OFF_STATUS, 0);
        chk(q, st());
        bus(1, usf_pkg::OFF_CONTROL, 32'h0000_0001);
        en = 1;
        chk_pin(tx_enable, 1'b1);
        bus(0, usf_pkg::OFF_CONTROL, 0);
        chk(q, 32'h0000_0001);
        for (int i = 0; i < 40; i++)
        begin
            r = $urandom;
            ev <= r[6:0];
            repeat (2) @(posedge mclk);
            sticky = sticky | ev[4:2];
            seen = seen | ev[4:2];
            bus(0, usf_pkg::OFF_STATUS, 0);
            chk(q, st());
            bus(0, usf_pkg::OFF_STATUS, 0);
            chk(q, st());
            // inputs held during the clear, so set-wins leaves live errors
            if (i % 8 == 7)
            begin
                bus(1, usf_pkg::OFF_CONTROL, 32'h0000_0101);
                sticky = ev[4:2];
            end
        end
        bus(1, usf_pkg::OFF_IRQ_EN, 32'h0000_0007);
        chk_pin(irq, |seen);
        ev <= 7'h00;
        repeat (2) @(posedge mclk);
        bus(1, usf_pkg::OFF_IRQ_CLR, 32'h0000_0007);
        chk_pin(irq, 1'b0);
        ev <= 7'h04;
        @(posedge mclk);
        ev <= 7'h00;
        bus(1, usf_pkg::OFF_IRQ_EN, 32'h0000_0000);
        chk_pin(irq, 1'b0);
        bus(1, usf_pkg::OFF_IRQ_EN, 32'h0000_0001);
        chk_pin(irq, 1'b1);
        bus(0, usf_pkg::OFF_IRQ_EN, 0);
        chk(q, 32'h0000_0001);
        bus(1, usf_pkg::OFF_IRQ_CLR, 32'h0000_001F);
        chk_pin(irq, 1'b0);
        // a rise on each dma end line leaves one sticky event apiece
        ev <= 7'h03;
        repeat (2) @(posedge mclk);
        ev <= 7'h00;
        bus(0, usf_pkg::OFF_IRQ_CLR, 0);
        chk(q, 32'h0000_0018);
        bus(1, usf_pkg::OFF_IRQ_EN, 32'h0000_0018);
        chk_pin(irq, 1'b1);
        bus(0, 4'h2, 0);
        chk(q, usf_pkg::READ_UNMAPPED);
        bus(1, usf_pkg::OFF_CONTROL, 32'h0000_0100);
        en = 0;
        chk_pin(tx_enable, 1'b0);
        sticky = 3'h0;
        bus(0, usf_pkg::OFF_STATUS, 0);
        chk(q, st());
        results();
    end
endmodule : usf_status_tb
